// [common/frao_params.svh]
// Constants for the file register ALU datapath.
// What this block does
// - Each operation carries a 7-bit register address (0..127) and one destination bit.
// - Destination bit 0 writes the accumulator; 1 writes back to the addressed register.
// - Increment adds one to the register, updates only the zero flag.
// - OR combines accumulator and register bitwise, updates only the zero flag.
// - Left shift: bit 7 to carry, bits 6..0 up, zero into bit 0, C and Z.
// - Right shift: bit 0 to carry, bits 7..1 down, zero into bit 7, C and Z.
// - Copy moves the register unchanged and updates zero; destination 1 tests it.
`ifndef FRAO_PARAMS_SVH
`define FRAO_PARAMS_SVH
`define FRAO_DATA_W     8
`define FRAO_ADDR_W     7
`define FRAO_ADDR_MAX   7'h7F
`define FRAO_DEST_ACCUM 1'b0
`define FRAO_DEST_REG   1'b1
`define FRAO_ACCUM_RST  8'h00
`define FRAO_ZERO_RST   1'b0
`define FRAO_CARRY_RST  1'b0
`define FRAO_WADDR_RST  7'h00
`define FRAO_WDATA_RST  8'h00
`endif

// [common/frao_pkg.sv]
// Types for the file register ALU datapath.
package frao_pkg;
  typedef enum logic [2:0] {
    increment_reg       = 3'h0,
    or_accum_reg        = 3'h1,
    shift_left_logical  = 3'h2,
    shift_right_logical = 3'h3,
    copy_reg            = 3'h4
  } frao_op_t;
endpackage

// [common/frao_alu_if.sv]
// Interface carrying operands and results between the top and the ALU core.
`timescale 1ns/10ps
interface frao_alu_if;
  import frao_pkg::*;
  frao_op_t   op;
  logic [7:0] src;
  logic [7:0] accum;
  logic [7:0] result;
  logic       carry;
  logic       carry_upd;
  logic       zero;
  modport core (input op, input src, input accum, output result, output carry,
                output carry_upd, output zero);
  modport ctrl (output op, output src, output accum, input result, input carry,
                input carry_upd, input zero);
endinterface

// [hdl/frao_alu_core.sv]
// Combinational ALU for the five file register operations.
`timescale 1ns/10ps
module frao_alu_core
  import frao_pkg::*;
(
  frao_alu_if.core alu
);
  // Computes result, carry and zero per operation.
  always_comb
  begin
    alu.carry     = 1'b0;
    alu.carry_upd = 1'b0;
    case (alu.op)
      increment_reg:       alu.result = 8'(alu.src + 8'h01); // Wraps at all ones.
      or_accum_reg:        alu.result = alu.accum | alu.src;
      shift_left_logical:
      begin
        alu.result    = {alu.src[6:0], 1'b0};
        alu.carry     = alu.src[7];
        alu.carry_upd = 1'b1;
      end
      shift_right_logical:
      begin
        alu.result    = {1'b0, alu.src[7:1]};
        alu.carry     = alu.src[0];
        alu.carry_upd = 1'b1;
      end
      copy_reg:            alu.result = alu.src;
      default:             alu.result = alu.src;
    endcase
    alu.zero = (alu.result == 8'h00);
  end
endmodule

// [hdl/frao_datapath.sv]
// File register ALU datapath: executes one operation per valid cycle.
`timescale 1ns/10ps
`include "frao_params.svh"
module frao_datapath
(
  input  wire logic               core_clk,   // Core clock.
  input  wire logic               arst_n,     // Asynchronous reset, active low.
  input  wire logic               op_valid,   // Executes the presented operation.
  input  wire frao_pkg::frao_op_t op_code,    // Operation to execute.
  input  wire logic [6:0]         reg_addr,   // Addressed register.
  input  wire logic               dest_sel,   // Destination bit.
  input  wire logic [7:0]         reg_rdata,  // Contents of the addressed register.
  output logic                    reg_we,     // Write-back strobe, one cycle.
  output logic [6:0]              reg_waddr,  // Write-back address.
  output logic [7:0]              reg_wdata,  // Write-back data.
  output logic [7:0]              accum,      // Accumulator.
  output logic                    carry_flag, // Carry status flag.
  output logic                    zero_flag   // Zero status flag.
);
  import frao_pkg::*;

  // Timing in brief. An operation is taken at the rising edge at which op_valid is high,
  // together with its code, address, destination bit and the operand on reg_rdata.
  // Every result appears one cycle later, straight from flip-flops, with no wait state.
  // Operations may follow each other on every cycle. The write-back of one operation
  // lands at the same edge at which the next one is taken, so the register file must
  // forward reg_wdata when that next operation reads the register being written.
  // The accumulator and both flags hold while op_valid is low.
  // The carry changes only on the two shifts; the zero flag follows every operation.
  // Codes outside the five operations behave as a copy and leave the carry alone.
  // The write-back address and data track every cycle; only reg_we marks a real write.

  // Carrier between this top and the combinational ALU.
  frao_alu_if alu ();

  // Feeds the core with the operand read from the addressed register.
  assign alu.op    = op_code;
  assign alu.src   = reg_rdata;
  assign alu.accum = accum;

  // Combinational ALU for the five operations.
  frao_alu_core frao_alu_core_i (.alu(alu));

  // Accumulator takes the result when the destination bit selects it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      accum <= `FRAO_ACCUM_RST;
    else if (op_valid && dest_sel == `FRAO_DEST_ACCUM)
      accum <= alu.result;
  end

  // Write-back port to the register file for destination bit set.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_we    <= 1'b0;
      reg_waddr <= `FRAO_WADDR_RST;
      reg_wdata <= `FRAO_WDATA_RST;
    end
    else
    begin
      reg_we    <= op_valid && dest_sel == `FRAO_DEST_REG;
      reg_waddr <= reg_addr; // Full 0..127 range.
      reg_wdata <= alu.result;
    end
  end

  // Zero flag updates on every operation; carry only on shifts.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_flag  <= `FRAO_ZERO_RST;
      carry_flag <= `FRAO_CARRY_RST;
    end
    else if (op_valid)
    begin
      zero_flag <= alu.zero;
      if (alu.carry_upd)
        carry_flag <= alu.carry;
    end
  end

  // Operation classes used by the checks below.
  logic op_shift;
  assign op_shift = op_code == shift_left_logical || op_code == shift_right_logical;

  // Checks on flags, results and destinations. Each looks one cycle after the edge that samples
  // its condition, where the registered outputs show what that edge took or held.

  // The zero flag mirrors the result in whichever destination was selected.
  zero_exact_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid
    |=> zero_flag == (($past(dest_sel) ? reg_wdata : accum) == 8'h00))
    else $error("zero flag does not match result");

  // Increment, OR and copy leave the carry alone.
  carry_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && (op_code == increment_reg || op_code == or_accum_reg || op_code == copy_reg)
    |=> $stable(carry_flag))
    else $error("carry changed on non-shift");

  // Any code other than a shift, the undefined ones included, keeps the carry.
  carry_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && !op_shift
    |=> $stable(carry_flag))
    else $error("carry changed on a code that is not a shift");

  // Left shift moves bit 7 into the carry.
  shl_carry_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_left_logical
    |=> carry_flag == $past(reg_rdata[7]))
    else $error("left shift carry wrong");

  // Left shift result: bits move up by one and a zero enters bit 0.
  shl_result_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_left_logical
    |=> ($past(dest_sel) ? reg_wdata : accum) == {$past(reg_rdata[6:0]), 1'b0})
    else $error("left shift result wrong");

  // Right shift moves bit 0 into the carry.
  shr_carry_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_right_logical
    |=> carry_flag == $past(reg_rdata[0]))
    else $error("right shift carry wrong");

  // Right shift result: bits move down by one and a zero enters bit 7.
  shr_result_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_right_logical
    |=> ($past(dest_sel) ? reg_wdata : accum) == {1'b0, $past(reg_rdata[7:1])})
    else $error("right shift result wrong");

  // Increment into the accumulator wraps within eight bits.
  inc_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == increment_reg && !dest_sel
    |=> accum == 8'($past(reg_rdata) + 8'h01))
    else $error("increment result wrong");

  // Increment written back to the register.
  inc_back_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == increment_reg && dest_sel
    |=> reg_wdata == 8'($past(reg_rdata) + 8'h01))
    else $error("increment write-back wrong");

  // Incrementing all ones gives zero and sets the zero flag.
  inc_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == increment_reg && reg_rdata == 8'hFF
    |=> zero_flag)
    else $error("increment wrap did not set zero");

  // OR written back to the register.
  or_accum_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == or_accum_reg && dest_sel
    |=> reg_wdata == ($past(reg_rdata) | $past(accum)))
    else $error("or result wrong");

  // OR into the accumulator.
  or_to_acc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == or_accum_reg && !dest_sel
    |=> accum == ($past(reg_rdata) | $past(accum)))
    else $error("or into accumulator wrong");

  // Copy back to the register is a zero test that leaves data intact.
  copy_test_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == copy_reg && dest_sel
    |=> reg_we && reg_wdata == $past(reg_rdata) && $stable(accum))
    else $error("copy test altered data");

  // Copy into the accumulator.
  copy_acc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == copy_reg && !dest_sel
    |=> accum == $past(reg_rdata) && !reg_we)
    else $error("copy into accumulator wrong");

  // Destination bit set writes the register and spares the accumulator.
  dest_reg_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && dest_sel
    |=> reg_we && reg_waddr == $past(reg_addr) && $stable(accum))
    else $error("write-back destination wrong");

  // No write-back strobe without an operation aimed at the register.
  dest_acc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(op_valid && dest_sel)
    |=> !reg_we)
    else $error("spurious write-back");

  // Without an operation the accumulator and both flags hold.
  idle_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !op_valid
    |=> $stable(accum) && $stable(zero_flag) && $stable(carry_flag))
    else $error("state changed while idle");

  // The write-back address follows the full seven-bit operand.
  waddr_track_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1
    |=> reg_waddr == $past(reg_addr))
    else $error("write-back address wrong");

  // Cover points for the main scenarios.
  // An increment that wraps from all ones to zero.
  cover_wrap_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == increment_reg && reg_rdata == 8'hFF);

  // A left shift that carries a one out.
  cover_shl_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_left_logical && reg_rdata[7]);

  // A right shift written back to the register.
  cover_shr_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == shift_right_logical && dest_sel);

  // A zero test on a register that holds zero.
  cover_test_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == copy_reg && dest_sel && reg_rdata == 8'h00);

  // An OR into a non-zero accumulator.
  cover_or_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_valid && op_code == or_accum_reg && !dest_sel && accum != 8'h00);
endmodule

// [verif/frao_regfile_model.sv]
// Behavioural register file that answers the datapath's reads.
`timescale 1ns/10ps
module frao_regfile_model
(
  input  wire logic       core_clk,
  input  wire logic       reg_we,
  input  wire logic [6:0] reg_addr,
  input  wire logic [6:0] reg_waddr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata
);
  logic [7:0] mem [128];
  // Reads forward a write landing this cycle, so back-to-back ops see fresh data.
  assign reg_rdata = (reg_we && reg_waddr == reg_addr) ? reg_wdata : mem[reg_addr];
  // Writes land at the clock edge; location 127 starts at all ones.
  always @(posedge core_clk) if (reg_we) mem[reg_waddr] <= reg_wdata;
  initial foreach (mem[i]) mem[i] = 8'(2 * i + 1);
endmodule

// [verif/file_register_alu_ops_bench.sv]
// Random and corner-case bench for the file register datapath.
`timescale 1ns/10ps
module file_register_alu_ops_bench;
  import frao_pkg::*;
  logic       core_clk = 0, arst_n = 0, op_valid = 0, dest_sel = 0, reg_we, carry_flag, zero_flag;
  logic       e_c = 0, e_z = 0;
  frao_op_t   op_code = increment_reg;
  logic [6:0] reg_addr = 0, reg_waddr;
  logic [7:0] reg_rdata, reg_wdata, accum, e_res, e_acc = 0;
  int         miscompares = 0, cmp_count = 0;
  frao_datapath frao_datapath_i (.core_clk, .arst_n, .op_valid, .op_code, .reg_addr,
    .dest_sel, .reg_rdata, .reg_we, .reg_waddr, .reg_wdata, .accum, .carry_flag, .zero_flag);
  frao_regfile_model frao_regfile_model_i (.core_clk, .reg_we, .reg_addr, .reg_waddr,
    .reg_wdata, .reg_rdata);
  // Expected 8-bit result of one operation.
  function automatic logic [7:0] alu(frao_op_t o, logic [7:0] s, logic [7:0] a);
    case (o)
      increment_reg:       return s + 8'h01;
      or_accum_reg:        return s | a;
      shift_left_logical:  return {s[6:0], 1'b0};
      shift_right_logical: return {1'b0, s[7:1]};
      default:             return s;
    endcase
  endfunction
  // Counts one comparison and reports a mismatch.
  task automatic chk(logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
    if (g !== e) miscompares++;
  endtask
  // Presents one op after a falling edge and checks the outputs one cycle later.
  task automatic run(frao_op_t o, logic [6:0] a, logic d);
    logic [7:0] s;
    op_valid = 1;
    op_code = o;
    reg_addr = a;
    dest_sel = d;
    #1 s = reg_rdata;
    e_res = alu(o, s, e_acc);
    if (o == shift_left_logical) e_c = s[7];
    if (o == shift_right_logical) e_c = s[0];
    e_z = (e_res == 8'h00);
    if (!d) e_acc = e_res;
    @(negedge core_clk);
    chk(accum, e_acc);
    chk({7'h00, carry_flag}, {7'h00, e_c});
    chk({7'h00, zero_flag}, {7'h00, e_z});
    chk({7'h00, reg_we}, {7'h00, d});
    if (d) chk(reg_wdata, e_res);
    if (d) chk({1'b0, reg_waddr}, {1'b0, a});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Free-running core clock with a 10 ns period.
  initial forever #5 core_clk = ~core_clk;
  // Watchdog well beyond the expected run time.
  initial
  begin
    #200000 miscompares++;
    results();
  end
  // Reset, corner cases, random operations, an idle spell and a reset in mid-run.
  initial
  begin
    void'($urandom(32'hF445E553));
    repeat (16) @(negedge core_clk);
    arst_n = 1;
    run(increment_reg, 7'h7F, 1'b1);
    run(copy_reg, 7'h7F, 1'b1);
    run(shift_left_logical, 7'h7E, 1'b0);
    run(shift_right_logical, 7'h00, 1'b0);
    run(or_accum_reg, 7'h01, 1'b1);
    run(frao_op_t'(3'h6), 7'h05, 1'b0);
    $display("corner test done");
    repeat (400) run(frao_op_t'($urandom_range(4)), 7'($urandom), 1'($urandom));
    $display("random test done");
    op_valid = 0;
    repeat (3) @(negedge core_clk);
    chk(accum, e_acc);
    chk({7'h00, reg_we}, 8'h00);
    chk({6'h00, carry_flag, zero_flag}, {6'h00, e_c, e_z});
    $display("idle test done");
    arst_n = 0;
    repeat (2) @(negedge core_clk);
    chk(accum, 8'h00);
    chk(reg_wdata, 8'h00);
    chk({1'b0, reg_waddr}, 8'h00);
    chk({5'h00, reg_we, carry_flag, zero_flag}, 8'h00);
    e_acc = 8'h00;
    e_c = 1'b0;
    e_z = 1'b0;
    arst_n = 1;
    run(or_accum_reg, 7'h02, 1'b0);
    run(shift_right_logical, 7'h01, 1'b1);
    $display("reset test done");
    results();
  end
endmodule
